// ==== rtl/pio_pin_control.sv ====
// Parallel I/O ports with pin control, ganged output and stop-mode latch hold
`timescale 1ns/1ns
module pio_pin_control
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [23:0] pin_in,
	input wire logic [23:0] periph_en,
	input wire logic [23:0] periph_oe,
	input wire logic [23:0] periph_out,
	input wire logic [23:0] analog_en,
	input wire logic debug_oe,
	input wire logic debug_out,
	input wire logic stop_request,
	input wire logic wake_request,
	output logic [23:0] pin_out,
	output logic [23:0] pin_oe,
	output logic [23:0] pin_pull_en,
	output logic [23:0] pin_slew_en,
	output logic [23:0] pin_drive_high,
	output logic [23:0] pin_ibuf_en,
	output logic io_hold
);

	// ****************************************
	// Register file
	// ****************************************
	logic [7:0] data_r [0:2];
	logic [7:0] pin_direction_bit_r [0:2];
	logic [7:0] pin_pull_enable_bit_r [0:2];
	logic [7:0] pin_slew_enable_bit_r [0:2];
	logic [7:0] pin_drive_high_bit_r [0:2];
	logic [7:0] ganged_output_control_r;
	logic debug_sel_r;
	logic power_down_recovered_flag_r;
	logic partial_sel_r;
	logic partial_locked_r;
	logic hold_r;
	logic ack_r;
	pio_pkg::pio_stop_type stop_r;
	logic [23:0] data_flat;
	logic [23:0] dir_flat;
	logic [23:0] pull_flat;
	logic [23:0] slew_flat;
	logic [23:0] drive_flat;
	logic [23:0] gang_mask;
	logic [23:0] oe_nxt;
	logic [23:0] out_nxt;
	logic [23:0] pull_nxt;
	logic [23:0] slew_nxt;
	logic [23:0] drive_nxt;
	logic [23:0] ibuf_nxt;
	logic [23:0] rd_bits;
	logic [31:0] rdata_nxt;
	logic wr_take;
	logic rd_take;
	logic reinit;
	logic ack_write;

	// Decode: kind 0 data, 1 direction, 2 pull, 3 slew, 4 drive; 7 means not a port register
	function automatic logic [4:0] pio_decode(input logic [9:0] a);
		logic [4:0] r;
		r = 5'h1F;
		for (int p = 0; p < pio_pkg::NPORT; p++)
		begin
			if (a == pio_pkg::PAGE_ZERO_BASE + 10'(p) * pio_pkg::PORT_STRIDE_LO)
				r = {2'(p), 3'h0};
			if (a == pio_pkg::PAGE_ZERO_BASE + 10'(p) * pio_pkg::PORT_STRIDE_LO + pio_pkg::DIR_OFS)
				r = {2'(p), 3'h1};
			if (a == pio_pkg::HIGH_PAGE_BASE + 10'(p) * pio_pkg::PORT_STRIDE_HI)
				r = {2'(p), 3'h2};
			if (a == pio_pkg::HIGH_PAGE_BASE + 10'(p) * pio_pkg::PORT_STRIDE_HI + pio_pkg::SLEW_OFS)
				r = {2'(p), 3'h3};
			if (a == pio_pkg::HIGH_PAGE_BASE + 10'(p) * pio_pkg::PORT_STRIDE_HI + pio_pkg::DRIVE_OFS)
				r = {2'(p), 3'h4};
		end
		return r;
	endfunction

	// Accept on the second cycle of a request; the first cycle prepares read data
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign wr_take = avs_write & ack_r & avs_byteenable[0];
	assign rd_take = avs_read & ~ack_r;
	assign ack_write = wr_take & (avs_address == pio_pkg::PM_ADDR) & avs_writedata[pio_pkg::PM_ACK_BIT];
	// Recovery from partial power-down loses register contents, so they restart at reset values
	assign reinit = sys_rst | (stop_r == pio_pkg::PIO_STOP_PARTIAL & wake_request);

	// Bus handshake phase
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			ack_r <= 1'b0;
		else
			ack_r <= (avs_read | avs_write) & ~ack_r;
	end

	// Port registers; pin controls have their own addresses so writes never cross over
	always_ff @(posedge mclk)
	begin
		if (reinit)
		begin
			for (int p = 0; p < pio_pkg::NPORT; p++)
			begin
				data_r[p] <= pio_pkg::DATA_RST;
				pin_direction_bit_r[p] <= pio_pkg::DIR_RST;
				pin_pull_enable_bit_r[p] <= pio_pkg::PULL_RST;
				pin_slew_enable_bit_r[p] <= pio_pkg::SLEW_RST;
				pin_drive_high_bit_r[p] <= pio_pkg::DRIVE_RST;
			end
		end
		else if (wr_take)
		begin
			for (int p = 0; p < pio_pkg::NPORT; p++)
			begin
				// Data latches in every bit whatever the direction
				if (pio_decode(avs_address) == {2'(p), 3'h0})
					data_r[p] <= avs_writedata[7:0];
				if (pio_decode(avs_address) == {2'(p), 3'h1})
					pin_direction_bit_r[p] <= avs_writedata[7:0];
				if (pio_decode(avs_address) == {2'(p), 3'h2})
					pin_pull_enable_bit_r[p] <= avs_writedata[7:0];
				if (pio_decode(avs_address) == {2'(p), 3'h3})
					pin_slew_enable_bit_r[p] <= avs_writedata[7:0];
				if (pio_decode(avs_address) == {2'(p), 3'h4})
					pin_drive_high_bit_r[p] <= avs_writedata[7:0];
			end
		end
	end

	// Ganged control and debug function select, both on the high page
	always_ff @(posedge mclk)
	begin
		if (reinit)
		begin
			ganged_output_control_r <= pio_pkg::GANG_RST;
			debug_sel_r <= pio_pkg::DEBUG_RST;
		end
		else if (wr_take)
		begin
			if (avs_address == pio_pkg::GANG_ADDR)
				ganged_output_control_r <= avs_writedata[7:0];
			if (avs_address == pio_pkg::DEBUG_ADDR)
				debug_sel_r <= avs_writedata[0];
		end
	end

	// ****************************************
	// Stop modes and power-down recovery
	// ****************************************
	// Stop mode is chosen by the write-once partial select at the moment of the stop request
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			stop_r <= pio_pkg::PIO_RUN;
		else
		begin
			unique case (stop_r)
				pio_pkg::PIO_RUN:
					if (stop_request)
						stop_r <= partial_sel_r ? pio_pkg::PIO_STOP_PARTIAL : pio_pkg::PIO_STOP_LIGHT;
				pio_pkg::PIO_STOP_LIGHT:
					if (wake_request)
						stop_r <= pio_pkg::PIO_RUN;
				pio_pkg::PIO_STOP_PARTIAL:
					if (wake_request)
						stop_r <= pio_pkg::PIO_RUN;
				default:
					stop_r <= pio_pkg::PIO_RUN;
			endcase
		end
	end

	// Write-once partial power-down select
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			partial_sel_r <= 1'b0;
			partial_locked_r <= 1'b0;
		end
		else if (wr_take && avs_address == pio_pkg::PM_ADDR && !partial_locked_r)
		begin
			partial_sel_r <= avs_writedata[pio_pkg::PM_PARTIAL_BIT];
			partial_locked_r <= 1'b1;
		end
	end

	// Recovered flag: a wake in the same cycle as the acknowledge keeps the flag set
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			power_down_recovered_flag_r <= 1'b0;
		else if (stop_r == pio_pkg::PIO_STOP_PARTIAL && wake_request)
			power_down_recovered_flag_r <= 1'b1;
		else if (ack_write)
			power_down_recovered_flag_r <= 1'b0;
	end

	// Latch hold from partial stop entry until the acknowledge after recovery
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			hold_r <= 1'b0;
		else if (stop_r == pio_pkg::PIO_RUN && stop_request && partial_sel_r)
			hold_r <= 1'b1;
		else if (ack_write && stop_r == pio_pkg::PIO_RUN)
			hold_r <= 1'b0;
	end
	assign io_hold = hold_r;

	// ****************************************
	// Pin priority logic
	// ****************************************
	always_comb
	begin
		gang_mask = '0;
		for (int k = 1; k <= 7; k++)
			gang_mask[pio_pkg::GANG_MAP[k]] = ganged_output_control_r[k];
		gang_mask[pio_pkg::MASTER_PIN] = 1'b1;
		if (!ganged_output_control_r[pio_pkg::GANG_EN_BIT])
			gang_mask = '0;
	end

	assign data_flat = {data_r[2], data_r[1], data_r[0]};
	assign dir_flat = {pin_direction_bit_r[2], pin_direction_bit_r[1], pin_direction_bit_r[0]};
	assign pull_flat = {pin_pull_enable_bit_r[2], pin_pull_enable_bit_r[1], pin_pull_enable_bit_r[0]};
	assign slew_flat = {pin_slew_enable_bit_r[2], pin_slew_enable_bit_r[1], pin_slew_enable_bit_r[0]};
	assign drive_flat = {pin_drive_high_bit_r[2], pin_drive_high_bit_r[1], pin_drive_high_bit_r[0]};

	// Analog first, then ganged, then debug on the output-only pin, then peripheral, then the port itself
	always_comb
	begin
		for (int i = 0; i < pio_pkg::NPIN; i++)
		begin
			out_nxt[i] = data_flat[i];
			drive_nxt[i] = drive_flat[i];
			slew_nxt[i] = slew_flat[i];
			oe_nxt[i] = dir_flat[i];
			ibuf_nxt[i] = (5'(i) != pio_pkg::OUTPUT_ONLY_PIN);
			if (analog_en[i])
			begin
				oe_nxt[i] = 1'b0;
				ibuf_nxt[i] = 1'b0;
			end
			else if (gang_mask[i])
			begin
				oe_nxt[i] = 1'b1;
				out_nxt[i] = data_flat[pio_pkg::MASTER_PIN];
				drive_nxt[i] = drive_flat[pio_pkg::MASTER_PIN];
				slew_nxt[i] = slew_flat[pio_pkg::MASTER_PIN];
			end
			else if (5'(i) == pio_pkg::OUTPUT_ONLY_PIN && debug_sel_r)
			begin
				oe_nxt[i] = debug_oe;
				out_nxt[i] = debug_out;
			end
			else if (periph_en[i])
			begin
				oe_nxt[i] = periph_oe[i];
				out_nxt[i] = periph_out[i];
			end
			slew_nxt[i] = slew_nxt[i] & oe_nxt[i];
			pull_nxt[i] = pull_flat[i] & ~oe_nxt[i] & ~analog_en[i];
			// Read source stays with the direction bit even under a shared function
			rd_bits[i] = dir_flat[i] ? data_flat[i] : (ibuf_nxt[i] & pin_in[i]);
		end
	end

	// Pad controls are registered; while held they keep the pre-stop state
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			pin_out <= '0;
			pin_oe <= '0;
			pin_pull_en <= '0;
			pin_slew_en <= '0;
			pin_drive_high <= '0;
			pin_ibuf_en <= '0;
		end
		else if (!hold_r)
		begin
			pin_out <= out_nxt;
			pin_oe <= oe_nxt;
			pin_pull_en <= pull_nxt;
			pin_slew_en <= slew_nxt;
			pin_drive_high <= drive_nxt;
			pin_ibuf_en <= ibuf_nxt;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// Unmapped addresses read zero; unused upper bits read zero
	always_comb
	begin
		rdata_nxt = '0;
		for (int p = 0; p < pio_pkg::NPORT; p++)
		begin
			if (pio_decode(avs_address) == {2'(p), 3'h0})
				rdata_nxt[7:0] = rd_bits[p*8 +: 8];
			if (pio_decode(avs_address) == {2'(p), 3'h1})
				rdata_nxt[7:0] = pin_direction_bit_r[p];
			if (pio_decode(avs_address) == {2'(p), 3'h2})
				rdata_nxt[7:0] = pin_pull_enable_bit_r[p];
			if (pio_decode(avs_address) == {2'(p), 3'h3})
				rdata_nxt[7:0] = pin_slew_enable_bit_r[p];
			if (pio_decode(avs_address) == {2'(p), 3'h4})
				rdata_nxt[7:0] = pin_drive_high_bit_r[p];
		end
		if (avs_address == pio_pkg::GANG_ADDR)
			rdata_nxt[7:0] = ganged_output_control_r;
		if (avs_address == pio_pkg::DEBUG_ADDR)
			rdata_nxt[0] = debug_sel_r;
		if (avs_address == pio_pkg::PM_ADDR)
		begin
			rdata_nxt[pio_pkg::PM_FLAG_BIT] = power_down_recovered_flag_r;
			rdata_nxt[pio_pkg::PM_PARTIAL_BIT] = partial_sel_r;
		end
	end

	// Read data captured in the waiting cycle so it stands at the accepting edge
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			avs_readdata <= '0;
		else if (rd_take)
			avs_readdata <= rdata_nxt;
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_analog_buffers_off: assert property ((analog_en[3] && !hold_r) |=> (!pin_oe[3] && !pin_ibuf_en[3]))
		else $error("analog pin still has a buffer on");
	a_analog_over_periph: assert property ((analog_en[9] && periph_en[9] && periph_oe[9] && !hold_r) |=> !pin_oe[9])
		else $error("peripheral drove a pin under analog control");
	a_periph_drives_oe: assert property ((periph_en[20] && !analog_en[20] && !gang_mask[20] && !hold_r)
		|=> pin_oe[20] == $past(periph_oe[20]))
		else $error("peripheral enable did not steer output enable");
	a_gang_master_out: assert property ((ganged_output_control_r[0] && !analog_en[16] && !hold_r) |=> pin_oe[16])
		else $error("master pin not forced to output while ganged");
	a_gang_follow_data: assert property ((gang_mask[13] && !analog_en[13] && !hold_r)
		|=> (pin_out[13] == $past(data_flat[16]) && pin_drive_high[13] == $past(drive_flat[16])))
		else $error("ganged pin does not follow the master pin");
	a_pull_off_output: assert property (pin_oe[7] |-> !pin_pull_en[7])
		else $error("pull device on while pin drives");
	a_slew_input_none: assert property (!pin_oe[12] |-> !pin_slew_en[12])
		else $error("slew limit applied to an input");
	a_only_pin_ibuf: assert property (!pin_ibuf_en[4])
		else $error("output-only pin has its input buffer on");
	a_hold_keeps_pads: assert property ((hold_r && $past(hold_r)) |-> $stable(pin_out) && $stable(pin_oe))
		else $error("pads changed while latches held");
	a_hold_on_partial: assert property ((stop_r == pio_pkg::PIO_RUN && stop_request && partial_sel_r) |=> hold_r)
		else $error("partial stop entry did not hold the latches");
	a_flag_ack_clear: assert property ((ack_write && !wake_request && stop_r == pio_pkg::PIO_RUN)
		|=> (!power_down_recovered_flag_r && !hold_r))
		else $error("acknowledge did not clear flag and hold");
	a_bus_one_wait: assert property ((avs_read || avs_write) && !ack_r |=> !avs_waitrequest [*1])
		else $error("bus answer not given one cycle after request");

endmodule

// ==== rtl/pio_pkg.sv ====
// Constants, register map and field layout for the parallel I/O pin control block
package pio_pkg;
	localparam int NPORT = 3;
	localparam int NPIN = 24;
	localparam logic [4:0] OUTPUT_ONLY_PIN = 5'h04;
	localparam logic [4:0] MASTER_PIN = 5'h10;
	// Byte addresses; low page for data/direction, high page for pin controls
	localparam logic [9:0] PAGE_ZERO_BASE = 10'h000;
	localparam logic [9:0] HIGH_PAGE_BASE = 10'h100;
	localparam logic [9:0] PORT_STRIDE_LO = 10'h008;
	localparam logic [9:0] PORT_STRIDE_HI = 10'h00C;
	localparam logic [9:0] DIR_OFS = 10'h004;
	localparam logic [9:0] SLEW_OFS = 10'h004;
	localparam logic [9:0] DRIVE_OFS = 10'h008;
	localparam logic [9:0] GANG_ADDR = 10'h124;
	localparam logic [9:0] PM_ADDR = 10'h128;
	localparam logic [9:0] DEBUG_ADDR = 10'h12C;
	// Reset values
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] PULL_RST = 8'h00;
	localparam logic [7:0] SLEW_RST = 8'hFF;
	localparam logic [7:0] DRIVE_RST = 8'h00;
	localparam logic [7:0] GANG_RST = 8'h00;
	localparam logic DEBUG_RST = 1'b1;
	// Power management and gang enable field positions
	localparam int PM_FLAG_BIT = 3;
	localparam int PM_ACK_BIT = 2;
	localparam int PM_PARTIAL_BIT = 0;
	localparam int GANG_EN_BIT = 0;
	// Ganged select bit 1..7 to flat pin index (port*8+bit)
	localparam logic [4:0] GANG_MAP [1:7] = '{5'h11, 5'h12, 5'h13, 5'h0A, 5'h0B, 5'h0C, 5'h0D};
	typedef enum logic [1:0] {PIO_RUN, PIO_STOP_LIGHT, PIO_STOP_PARTIAL} pio_stop_type;
endpackage

// ==== sim/pio_board.sv ====
// Board-side model of the pads: external drivers, pull-ups and floating lines
`timescale 1ns/1ns
module pio_board
(
	input wire logic mclk,
	input wire logic [23:0] pin_out,
	input wire logic [23:0] pin_oe,
	input wire logic [23:0] pin_pull_en,
	input wire logic [23:0] ext_drive,
	input wire logic [23:0] ext_val,
	output logic [23:0] pin_in
);
	logic [23:0] float_r = '0;
	// Undriven lines flip every cycle, so a stale level is never trusted
	always_ff @(posedge mclk)
	begin
		float_r <= ~pin_in;
	end
	// Pad driver wins, then the board driver, then the pull-up
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_val)
		| (~pin_oe & ~ext_drive & (pin_pull_en | float_r));
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the parallel I/O pin control block
`timescale 1ns/1ns
module tb_top;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [9:0] avs_address = 10'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [23:0] pin_in, periph_en, periph_oe, periph_out, analog_en, ext_drive, ext_val;
	logic debug_oe, debug_out, stop_request, wake_request, io_hold;
	logic [23:0] pin_out, pin_oe, pin_pull_en, pin_slew_en, pin_drive_high, pin_ibuf_en;
	logic [23:0] e_oe, e_out, e_pu, e_sl, e_dv, e_ib;
	logic [7:0] mr [5][3];
	logic [7:0] m_gang;
	logic m_dbg;
	logic [7:0] rd;
	int error_cnt = 0;
	int comparisons = 0;
	integer seed = 32'hf753_5f01;

	// Free-running 250 MHz clock
	always #2 mclk = ~mclk;

	pio_pin_control dut_u (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_in, .periph_en, .periph_oe, .periph_out,
		.analog_en, .debug_oe, .debug_out, .stop_request, .wake_request, .pin_out, .pin_oe, .pin_pull_en,
		.pin_slew_en, .pin_drive_high, .pin_ibuf_en, .io_hold);
	pio_board board_u (.mclk, .pin_out, .pin_oe, .pin_pull_en, .ext_drive, .ext_val, .pin_in);

	// ********************************
	// Verdict, compare and bus helpers
	// ********************************
	task automatic stop_test();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Request held until waitrequest is sampled low at a rising edge; read data is taken at that same edge
	task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
		int n;
		@(posedge mclk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {24'h00_0000, d};
		avs_byteenable <= be;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0)
		begin
			error_cnt++;
			stop_test();
		end
		else
		begin
			rd = avs_readdata[7:0];
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask

	// Kind 0 data, 1 direction, 2 pull, 3 slew, 4 drive
	function automatic logic [9:0] ra(input int k, input int p);
		if (k < 2)
			return pio_pkg::PAGE_ZERO_BASE + 10'(p) * pio_pkg::PORT_STRIDE_LO + (k == 1 ? pio_pkg::DIR_OFS : 10'h000);
		return pio_pkg::HIGH_PAGE_BASE + 10'(p) * pio_pkg::PORT_STRIDE_HI + 10'(k - 2) * 10'h004;
	endfunction

	function automatic logic [23:0] fl(input int k);
		return {mr[k][2], mr[k][1], mr[k][0]};
	endfunction

	task automatic wr(input int k, input int p, input logic [7:0] d);
		bus(1'b1, ra(k, p), d, 4'hF);
		mr[k][p] = d;
	endtask

	task automatic mr_reset();
		foreach (mr[k, p])
			mr[k][p] = (k == 3) ? pio_pkg::SLEW_RST : 8'h00;
		m_gang = pio_pkg::GANG_RST;
		m_dbg = pio_pkg::DEBUG_RST;
	endtask

	task automatic pulse(input logic w);
		@(posedge mclk);
		wake_request <= w;
		stop_request <= ~w;
		@(posedge mclk);
		wake_request <= 1'b0;
		stop_request <= 1'b0;
	endtask

	// Pads lag the accepting edge by one cycle; wait past it
	task automatic settle();
		repeat (3) @(posedge mclk);
		@(negedge mclk);
	endtask

	// Expected pads: analog, then ganged, then debug pin, then peripheral, then port
	task automatic check_pads();
		logic [23:0] gs, dt, dr, sl, dv;
		gs = '0;
		dt = fl(0);
		dr = fl(1);
		sl = fl(3);
		dv = fl(4);
		if (m_gang[0])
		begin
			gs[16] = 1'b1;
			for (int b = 1; b < 8; b++)
				gs[pio_pkg::GANG_MAP[b]] = m_gang[b];
		end
		for (int i = 0; i < 24; i++)
		begin
			e_oe[i] = analog_en[i] ? 1'b0 : gs[i] ? 1'b1 : (i == 4 && m_dbg) ? debug_oe : periph_en[i] ? periph_oe[i] : dr[i];
			e_out[i] = gs[i] ? dt[16] : (i == 4 && m_dbg) ? debug_out : periph_en[i] ? periph_out[i] : dt[i];
			e_dv[i] = gs[i] ? dv[16] : dv[i];
			e_sl[i] = (gs[i] ? sl[16] : sl[i]) & e_oe[i];
		end
		e_pu = fl(2) & ~e_oe & ~analog_en;
		e_ib = ~analog_en & 24'hFF_FFEF;
		chk("pin_oe", e_oe, pin_oe);
		chk("pin_out", e_out & e_oe, pin_out & e_oe);
		chk("pin_pull_en", e_pu, pin_pull_en);
		chk("pin_slew_en", e_sl, pin_slew_en);
		chk("pin_drive_high", e_dv & e_oe, pin_drive_high & e_oe);
		chk("pin_ibuf_en", e_ib, pin_ibuf_en);
	endtask

	// Reads every port register; floating inputs are left out of the data compare
	task automatic check_read();
		logic [23:0] g, det;
		det = fl(1) | e_oe | ext_drive | e_pu | ~e_ib;
		for (int k = 0; k < 5; k++)
		begin
			for (int p = 0; p < 3; p++)
			begin
				bus(1'b0, ra(k, p), 8'h00, 4'hF);
				g[8 * p +: 8] = rd;
			end
			if (k == 0)
				chk("data read", ((fl(1) & fl(0)) | (~fl(1) & e_ib & pin_in)) & det, g & det);
			else
				chk("register read", fl(k), g);
		end
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial
	begin
		int p;
		logic [7:0] v;
		logic [23:0] so;
		logic [9:0] ta [4];
		logic [7:0] te [4];
		{periph_en, periph_oe, periph_out, analog_en, ext_drive, ext_val} = '0;
		{debug_oe, debug_out, stop_request, wake_request} = '0;
		mr_reset();
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		settle();
		check_pads();
		check_read();
		ta = '{pio_pkg::GANG_ADDR, pio_pkg::PM_ADDR, pio_pkg::DEBUG_ADDR, 10'h1F0};
		te = '{pio_pkg::GANG_RST, 8'h00, 8'h01, 8'h00};
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b0, ta[i], 8'h00, 4'hF);
			chk("reset read", 24'(te[i]), 24'(rd));
		end
		// Random pin traffic; data always written before direction
		repeat (24)
		begin
			@(posedge mclk);
			periph_en <= 24'($random(seed));
			periph_oe <= 24'($random(seed));
			periph_out <= 24'($random(seed));
			analog_en <= 24'($random(seed) & $random(seed) & $random(seed));
			ext_drive <= 24'($random(seed));
			ext_val <= 24'($random(seed));
			{debug_oe, debug_out} <= 2'($random(seed));
			p = {$random(seed)} % 3;
			for (int k = 0; k < 5; k++)
				wr(k, p, 8'($random(seed)));
			v = 8'($random(seed));
			bus(1'b1, pio_pkg::GANG_ADDR, v, 4'hF);
			m_gang = v;
			// Debug select is random so the output-only pin also falls back to its port bits
			v = 8'($random(seed));
			bus(1'b1, pio_pkg::DEBUG_ADDR, v, 4'hF);
			m_dbg = v[0];
			settle();
			check_pads();
			check_read();
		end
		// Light stop on random settings must leave every pad and register alone
		pulse(1'b0);
		settle();
		chk("io_hold light", 24'h0, 24'(io_hold));
		pulse(1'b1);
		settle();
		check_pads();
		check_read();
		// Gang everything over enabled peripherals, one analog pin, master as input
		@(posedge mclk);
		periph_en <= '1;
		periph_oe <= '0;
		analog_en <= 24'h00_0800;
		wr(1, 2, 8'h00);
		wr(0, 2, 8'h01);
		bus(1'b1, pio_pkg::GANG_ADDR, 8'hFF, 4'hF);
		bus(1'b1, pio_pkg::GANG_ADDR, 8'h00, 4'h0);
		m_gang = 8'hFF;
		bus(1'b0, pio_pkg::GANG_ADDR, 8'h00, 4'hF);
		chk("gang read", 24'h00_00FF, 24'(rd));
		settle();
		check_pads();
		chk("master oe", 24'h1, 24'(pin_oe[16]));
		// Partial power-down stop and recovery
		bus(1'b1, pio_pkg::PM_ADDR, 8'h01, 4'hF);
		pulse(1'b0);
		settle();
		chk("io_hold set", 24'h1, 24'(io_hold));
		so = pin_oe;
		pulse(1'b1);
		settle();
		// Software looks at the recovered flag before it touches any port register
		bus(1'b0, pio_pkg::PM_ADDR, 8'h00, 4'hF);
		chk("flag set", 24'h1, 24'(rd[pio_pkg::PM_FLAG_BIT]));
		mr_reset();
		wr(0, 1, 8'hA5);
		wr(1, 1, 8'hFF);
		settle();
		chk("held oe", so, pin_oe);
		bus(1'b1, pio_pkg::PM_ADDR, 8'h04, 4'hF);
		bus(1'b0, pio_pkg::PM_ADDR, 8'h00, 4'hF);
		chk("flag clear", 24'h0, 24'(rd[pio_pkg::PM_FLAG_BIT]));
		settle();
		chk("io_hold clear", 24'h0, 24'(io_hold));
		check_pads();
		stop_test();
	end

	// Hang guard far beyond the length of the test
	initial
	begin
		#300000;
		error_cnt++;
		stop_test();
	end
endmodule
